//--- pcg_pkg.sv
/*
  Constants for the configuration header fields and the indexed register
  gateway. Assumes a single clock domain and a simple PCI-side access port.
*/
`default_nettype none
package pcg_pkg;
  // ************************************************
  // Configuration offsets
  // ************************************************
  localparam logic [7:0] CFG_CLASS_REV = 8'h08;
  localparam logic [7:0] CFG_HDR_WORD = 8'h0c;
  localparam logic [7:0] CFG_IO_BASE = 8'h10;
  localparam logic [7:0] CFG_INT_INFO = 8'h3c;
  localparam logic [7:0] CFG_COMMAND = 8'h04;
  // ************************************************
  // Field values
  // ************************************************
  localparam logic [23:0] CLASS_BRIDGE = 24'h060500;
  localparam logic [7:0] HEADER_MULTI = 8'h80;
  localparam logic [7:0] INT_PIN_VAL = 8'h00;
  localparam logic [7:0] MAX_LAT_VAL = 8'h00;
  localparam int IO_SPACE_BIT = 0;
  localparam int BASE_LSB = 2;
  // Gateway byte lanes within the decoded word
  localparam logic [1:0] GW_SELECT_LANE = 2'h0;
  localparam logic [1:0] GW_DATA_LANE = 2'h1;
  localparam logic [7:0] GW_SELECT_RST = 8'h00;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam int SOCKET_BIT = 6;
  localparam int REG_IDX_W = 6;
endpackage
`default_nettype wire

//--- pcg_config_gateway.sv
/*
  Configuration header fields and index/data gateway of a two-socket
  PC-card bridge. Assumes the host delivers configuration and I/O accesses as
  single-cycle strobes with byte enables, and that the per-socket register
  file lives outside, reached through the reg_* port.
*/
// Summary of operation
// (RULE_01) Low byte of class word is a read-only silicon revision value.
// (RULE_02) Upper 24 class bits always read the bridge class code.
// (RULE_03) Header type byte always reads the multi-function constant.
// (RULE_04) Base address bit 0 always reads one, marking I/O space.
// (RULE_05) Base address bits 31 to 2 are read and write.
// (RULE_06) No gateway decode while the programmed base is zero.
// (RULE_07) Interrupt line byte is plain storage without routing effect.
// (RULE_08) Interrupt pin byte always reads zero.
// (RULE_09) Maximum latency byte always reads zero.
// (RULE_10) Select byte at base, data at base plus one, rest ignored.
// (RULE_11) Select bits 5 to 0 choose one of 64 socket registers.
// (RULE_12) Software avoids reserved register offsets; hardware passes them through.
// (RULE_13) Select bit 6 chooses socket A or socket B.
// (RULE_14) Low seven select bits name one internal register byte.
// (RULE_15) Data accesses go to the register named by the current select.
// (RULE_16) Gateway answers only while the I/O space enable bit is set.
// (RULE_17) Select bit 7 is reserved, resets to zero and reads zero.
// (RULE_18) Writes to read-only fields are taken and change nothing.
`default_nettype none
module pcg_config_gateway
  import pcg_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h01  // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration access strobe
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // I/O space access strobe
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [31:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic io_hit,
  output logic [31:0] io_rdata,
  // Per-socket internal register port
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_socket,
  output logic [5:0] reg_index,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // I/O space enable from the command register
  input wire logic io_space_en
);
  import pcg_pkg::*;

  // ************************************************
  // Stored configuration state
  // ************************************************
  logic [31:BASE_LSB] io_base;
  logic [7:0] int_line;
  logic [6:0] gw_select;
  logic [31:0] cfg_rdata_q;
  logic [31:0] io_rdata_q;
  logic [31:BASE_LSB] next_io_base;
  logic [7:0] next_int_line;
  logic [6:0] next_gw_select;
  logic [31:0] next_cfg_rdata;
  logic [31:0] next_io_rdata;

  logic base_valid;
  logic gw_hit;
  logic sel_lane;
  logic data_lane;

  // Decode of the gateway word; zero base and disabled I/O space stay silent
  assign base_valid = (io_base != '0); // RULE_06
  assign gw_hit = io_space_en && base_valid && (io_addr[31:BASE_LSB] == io_base); // RULE_16 RULE_10
  assign sel_lane = io_be[GW_SELECT_LANE]; // RULE_10
  assign data_lane = io_be[GW_DATA_LANE]; // RULE_10
  assign io_hit = gw_hit;

  // Data byte goes straight to the register named by the live select
  assign reg_socket = gw_select[SOCKET_BIT]; // RULE_13 RULE_14
  assign reg_index = gw_select[REG_IDX_W-1:0]; // RULE_11 RULE_15
  assign reg_rd = gw_hit && io_rd && data_lane; // RULE_15
  assign reg_wr = gw_hit && io_wr && data_lane; // RULE_15
  assign reg_wdata = io_wdata[15:8];

  // Next state of the writable configuration fields
  always_comb begin
    next_io_base = io_base;
    next_int_line = int_line;
    next_gw_select = gw_select;
    if (cfg_wr && cfg_addr == CFG_IO_BASE) begin
      // Bit 0 and 1 are not stored; lanes merge byte by byte
      if (cfg_be[0]) next_io_base[7:2] = cfg_wdata[7:2]; // RULE_05
      if (cfg_be[1]) next_io_base[15:8] = cfg_wdata[15:8]; // RULE_05
      if (cfg_be[2]) next_io_base[23:16] = cfg_wdata[23:16]; // RULE_05
      if (cfg_be[3]) next_io_base[31:24] = cfg_wdata[31:24]; // RULE_05
    end
    if (cfg_wr && cfg_addr == CFG_INT_INFO && cfg_be[0]) begin
      next_int_line = cfg_wdata[7:0]; // RULE_07
    end
    // Bit 7 is never stored, so it cannot come back as one
    if (gw_hit && io_wr && sel_lane) begin
      next_gw_select = io_wdata[6:0]; // RULE_17
    end
  end

  // Read data; constants ignore any write to them
  always_comb begin
    next_cfg_rdata = 32'h0000_0000;
    next_io_rdata = 32'h0000_0000;
    if (cfg_rd) begin
      unique case (cfg_addr)
        CFG_CLASS_REV: next_cfg_rdata = {CLASS_BRIDGE, SILICON_REVISION}; // RULE_01 RULE_02 RULE_18
        CFG_HDR_WORD: next_cfg_rdata = {8'h00, HEADER_MULTI, 16'h0000}; // RULE_03 RULE_18
        CFG_IO_BASE: next_cfg_rdata = {io_base, 1'b0, 1'b1}; // RULE_04 RULE_05
        CFG_INT_INFO: next_cfg_rdata = {MAX_LAT_VAL, 8'h00, INT_PIN_VAL, int_line}; // RULE_08 RULE_09
        default: next_cfg_rdata = 32'h0000_0000;
      endcase
    end
    if (gw_hit && io_rd) begin
      // Bytes at base plus two and three read as zero
      next_io_rdata = {16'h0000, reg_rdata, 1'b0, gw_select}; // RULE_10 RULE_17
    end
  end

  // Register stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_base <= '0;
      int_line <= INT_LINE_RST;
      gw_select <= GW_SELECT_RST[6:0]; // RULE_17
      cfg_rdata_q <= 32'h0000_0000;
      io_rdata_q <= 32'h0000_0000;
    end else begin
      io_base <= next_io_base;
      int_line <= next_int_line;
      gw_select <= next_gw_select;
      cfg_rdata_q <= next_cfg_rdata;
      io_rdata_q <= next_io_rdata;
    end
  end

  assign cfg_rdata = cfg_rdata_q;
  assign io_rdata = io_rdata_q;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_class_const: assert property (cfg_rd && cfg_addr == CFG_CLASS_REV |=> // RULE_02
    cfg_rdata == {CLASS_BRIDGE, SILICON_REVISION}) else $error("class word wrong");
  chk_header_const: assert property (cfg_rd && cfg_addr == CFG_HDR_WORD |=> // RULE_03
    cfg_rdata[23:16] == HEADER_MULTI) else $error("header type wrong");
  chk_io_indicator: assert property (cfg_rd && cfg_addr == CFG_IO_BASE |=> // RULE_04
    cfg_rdata[1:0] == 2'b01) else $error("I/O indicator wrong");
  sequence base_full_write;
    cfg_wr && cfg_addr == CFG_IO_BASE && cfg_be == 4'hf && !cfg_rd;
  endsequence
  chk_base_rw: assert property (base_full_write ##1 (cfg_rd && cfg_addr == CFG_IO_BASE) |=> // RULE_05
    cfg_rdata[31:2] == $past(cfg_wdata[31:2], 2)) else $error("base not stored");
  chk_zero_base: assert property (io_base == '0 |-> !io_hit && !reg_rd && !reg_wr) // RULE_06
    else $error("decode with zero base");
  chk_int_info: assert property (cfg_rd && cfg_addr == CFG_INT_INFO |=> // RULE_08
    cfg_rdata[31:8] == 24'h000000) else $error("pin or latency not zero");
  chk_int_line: assert property (cfg_wr && cfg_addr == CFG_INT_INFO && cfg_be[0] |=> // RULE_07
    int_line == $past(cfg_wdata[7:0])) else $error("line byte lost");
  chk_io_enable: assert property (!io_space_en |-> !io_hit && !reg_wr) // RULE_16
    else $error("decode while disabled");
  chk_select_follow: assert property (gw_hit && io_wr && sel_lane |=> // RULE_15
    {reg_socket, reg_index} == $past(io_wdata[6:0])) else $error("select not applied");
  chk_reserved_bit: assert property (gw_hit && io_rd |=> io_rdata[7] == 1'b0) // RULE_17
    else $error("reserved select bit set");

  // ************************************************
  // Identification and interrupt byte checks
  // ************************************************
  // Revision byte is the build-time value, never bus data
  chk_revision_byte: assert property (cfg_rd && cfg_addr == CFG_CLASS_REV |=> // RULE_01
    cfg_rdata[7:0] == SILICON_REVISION)
    else $error("revision byte wrong");

  // A write to the class word is swallowed; the next read is unchanged
  sequence class_write_then_read;
    (cfg_wr && cfg_addr == CFG_CLASS_REV) ##1 (cfg_rd && cfg_addr == CFG_CLASS_REV);
  endsequence
  chk_class_after_write: assert property (class_write_then_read |=> // RULE_18
    cfg_rdata == {CLASS_BRIDGE, SILICON_REVISION})
    else $error("class word changed by write");

  // Pin and latency bytes stay at their constants
  chk_pin_byte: assert property (cfg_rd && cfg_addr == CFG_INT_INFO |=> // RULE_08
    cfg_rdata[15:8] == INT_PIN_VAL)
    else $error("pin byte not zero");

  chk_latency_byte: assert property (cfg_rd && cfg_addr == CFG_INT_INFO |=> // RULE_09
    cfg_rdata[31:24] == MAX_LAT_VAL)
    else $error("latency byte not zero");

  // Line byte reads back what was stored; only a lane 0 write moves it
  chk_line_readback: assert property (cfg_rd && cfg_addr == CFG_INT_INFO |=> // RULE_07
    cfg_rdata[7:0] == $past(int_line))
    else $error("line byte read back wrong");

  chk_line_hold: assert property (!(cfg_wr && cfg_addr == CFG_INT_INFO && cfg_be[0]) |=> // RULE_07
    $stable(int_line))
    else $error("line byte moved without write");

  // ************************************************
  // Base address checks
  // ************************************************
  // Each lane of the base moves only under its own byte enable
  chk_base_low_lane: assert property (cfg_wr && cfg_addr == CFG_IO_BASE && cfg_be[0] |=> // RULE_05
    io_base[7:2] == $past(cfg_wdata[7:2]))
    else $error("base low lane not stored");

  chk_base_top_hold: assert property (cfg_wr && cfg_addr == CFG_IO_BASE && !cfg_be[3] |=> // RULE_05
    io_base[31:24] == $past(io_base[31:24]))
    else $error("base top lane moved");

  // Without a base write the decode address is frozen
  chk_base_hold: assert property (!(cfg_wr && cfg_addr == CFG_IO_BASE) |=> $stable(io_base)) // RULE_05
    else $error("base moved without write");

  // Base read shows the stored bits above the two fixed ones
  chk_base_readback: assert property (cfg_rd && cfg_addr == CFG_IO_BASE |=> // RULE_05
    cfg_rdata[31:2] == $past(io_base))
    else $error("base read back wrong");

  // ************************************************
  // Gateway decode checks
  // ************************************************
  // Internal strobes only for a hit on the data lane
  chk_write_strobe: assert property (reg_wr |-> io_hit && io_wr && io_be[GW_DATA_LANE]) // RULE_10
    else $error("write strobe off the data lane");

  chk_read_strobe: assert property (reg_rd |-> io_hit && io_rd && io_be[GW_DATA_LANE]) // RULE_10
    else $error("read strobe off the data lane");

  // A matching word with a live base and enabled space must hit
  chk_hit_decode: assert property (io_space_en && io_base != '0 && io_addr[31:BASE_LSB] == io_base |-> // RULE_10
    io_hit)
    else $error("decoded word missed");

  // A data lane hit must reach the register file intact
  chk_data_reaches: assert property (io_hit && (io_wr || io_rd) && io_be[GW_DATA_LANE] |-> // RULE_15
    (reg_wr == io_wr) && (reg_rd == io_rd) && (reg_wdata == io_wdata[15:8]))
    else $error("data lane access lost");

  // Disabled space or a zero base gives no internal read either
  chk_read_gated: assert property (!io_space_en || io_base == '0 |-> !reg_rd) // RULE_06 RULE_16
    else $error("internal read while not decoding");

  // Only a select lane hit moves the select
  chk_select_hold: assert property (!(io_hit && io_wr && io_be[GW_SELECT_LANE]) |=> // RULE_10 RULE_06
    $stable(gw_select))
    else $error("select moved without a select write");

  // Read word: select in the low byte, register byte above, top half zero
  chk_read_select: assert property (io_hit && io_rd |=> // RULE_11 RULE_13
    io_rdata[6:0] == $past({reg_socket, reg_index}))
    else $error("select read back wrong");

  chk_read_data: assert property (io_hit && io_rd && io_be[GW_DATA_LANE] |=> // RULE_15
    io_rdata[15:8] == $past(reg_rdata))
    else $error("register byte not returned");

  chk_read_upper: assert property (io_hit && io_rd |=> io_rdata[31:16] == 16'h0000) // RULE_10
    else $error("ignored lanes not zero");

  // Anything but a decoded read leaves the read word at zero
  chk_miss_silent: assert property (!(io_hit && io_rd) |=> io_rdata == 32'h0000_0000) // RULE_06 RULE_16
    else $error("read data without a decoded read");

  // A write alone never puts anything on the configuration read word
  chk_cfg_quiet: assert property (!cfg_rd |=> // RULE_18
    cfg_rdata == 32'h0000_0000)
    else $error("config read data without a read");

  // Select write followed by a data access must use the new select
  sequence select_write;
    io_hit && io_wr && io_be[GW_SELECT_LANE];
  endsequence
  sequence data_access;
    io_hit && (io_wr || io_rd) && io_be[GW_DATA_LANE];
  endsequence
  chk_select_then_data: assert property (select_write ##1 data_access |-> // RULE_14 RULE_15
    {reg_socket, reg_index} == $past(io_wdata[6:0]))
    else $error("data access used a stale select");

  // Leaving reset, select, base and line byte start from their reset values
  chk_select_reset: assert property ($rose(arst_n) |-> // RULE_17
    gw_select == GW_SELECT_RST[6:0] && io_base == '0 && int_line == INT_LINE_RST)
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

//--- pcg_socket_model.sv
/*
  Model of the per-socket register file behind the gateway.
  Assumes reg_* strobes from the gateway, one clock.
*/
`default_nettype none
module pcg_socket_model (
  // Clock
  input wire logic mclk,
  // Register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_socket,
  input wire logic [5:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  // Socket bit above the index names one byte
  always @(posedge mclk) if (reg_wr) mem[{reg_socket, reg_index}] <= reg_wdata;
  // Junk outside a read, so a stale byte cannot pass
  assign reg_rdata = reg_rd ? mem[{reg_socket, reg_index}] : ~mem[{reg_socket, reg_index}];
endmodule
`default_nettype wire

//--- pci_config_and_index_access_tb.sv
/*
  Bench for the configuration fields and index gateway.
  Assumes pcg_pkg and the socket model are compiled first.
*/
`default_nettype none
module pci_config_and_index_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;
  localparam logic [7:0] REV = 8'h01;  // Arbitrary value
  localparam logic [31:0] BASE = 32'h00001230;
  logic mclk = 0, arst_n = 0, cfg_rd = 0, cfg_wr = 0, io_rd = 0, io_wr = 0, io_space_en = 0;
  logic [7:0] cfg_addr = 0, reg_wdata, reg_rdata;
  logic [3:0] cfg_be = 0, io_be = 0;
  logic [31:0] cfg_wdata = 0, io_addr = 0, io_wdata = 0, cfg_rdata, io_rdata, q;
  logic io_hit, reg_rd, reg_wr, reg_socket, h;
  logic [5:0] reg_index;
  int num_errors = 0, checks = 0;
  pcg_config_gateway #(.SILICON_REVISION(REV)) pcg_config_gateway_inst (.mclk(mclk), .arst_n(arst_n),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_be(io_be),
    .io_wdata(io_wdata), .io_hit(io_hit), .io_rdata(io_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_socket(reg_socket), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .io_space_en(io_space_en));
  pcg_socket_model pcg_socket_model_inst (.mclk(mclk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_socket(reg_socket), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ****
  // Shared tasks; each starts and ends 1 ns after an edge
  // ****
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes stay up until the next call replaces them, so no signal is set twice in one step
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {w, !w, a, d, be};
    {io_wr, io_rd} = 2'b00;
    @(posedge mclk);
    #1;
    q = cfg_rdata;
  endtask
  task automatic io(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    {io_wr, io_rd, io_addr, io_be, io_wdata} = {w, !w, a, be, d};
    {cfg_wr, cfg_rd} = 2'b00;
    #1;
    h = io_hit;  // Hit is combinational, look before the edge
    @(posedge mclk);
    #1;
    q = io_rdata;
  endtask
  task automatic t_cfg;
    cfg(1, CFG_CLASS_REV, 32'hffffffff);
    cfg(0, CFG_CLASS_REV, 0);
    chk("class", q, {CLASS_BRIDGE, REV});
    cfg(0, CFG_HDR_WORD, 0);
    chk("header", q[23:16], HEADER_MULTI);
    cfg(0, CFG_INT_INFO, 0);
    chk("int rst", {q[31:24], q[15:0]}, {MAX_LAT_VAL, INT_PIN_VAL, INT_LINE_RST});
    cfg(1, CFG_INT_INFO, 32'hffffffff);
    cfg(0, CFG_INT_INFO, 0);
    chk("int", {q[31:24], q[15:0]}, 24'h0000ff);
    cfg(1, CFG_INT_INFO, 0, 4'he);
    cfg(0, CFG_INT_INFO, 0);
    chk("int lane", q[7:0], 8'hff);
    $display("test cfg done");
  endtask
  task automatic t_base;
    cfg(0, CFG_IO_BASE, 0);
    chk("base rst", q, 32'h1);
    io_space_en = 1;
    io(1, 0, 4'h1, 32'h45);
    chk("hit zero", h, 0);
    cfg(1, CFG_IO_BASE, 32'hffffffff);
    cfg(0, CFG_IO_BASE, 0);
    chk("base", q, 32'hfffffffd);
    cfg(1, CFG_IO_BASE, 0, 4'h1);
    cfg(0, CFG_IO_BASE, 0);
    chk("base lane", q, 32'hffffff01);
    cfg(1, CFG_IO_BASE, BASE);
    io_space_en = 0;
    io(1, BASE, 4'h1, 32'h45);
    chk("hit off", h, 0);
    io_space_en = 1;
    $display("test base done");
  endtask
  task automatic t_gw;
    io(0, BASE, 4'h1, 0);
    chk("sel rst", q[7:0], GW_SELECT_RST);
    io(1, BASE, 4'h1, 32'h45);
    chk("sel out", {reg_socket, reg_index}, 7'h45);
    io(1, BASE + 1, 4'h2, 32'ha500);
    chk("data hit", h, 1);
    io(1, BASE, 4'h1, 32'h85);
    io(1, BASE + 1, 4'h2, 32'h3c00);
    io(1, BASE + 2, 4'hc, 32'h4a4a0000);
    io(0, BASE, 4'h1, 0);
    chk("sel b7", q[7:0], 8'h05);
    io(1, BASE, 4'h1, 32'h45);
    io(0, BASE + 1, 4'h2, 0);
    chk("data b", q[15:8], 8'ha5);
    io(1, BASE, 4'h1, 32'h05);
    io(0, BASE + 1, 4'h2, 0);
    chk("data a", q[15:8], 8'h3c);
    io(0, BASE + 4, 4'h2, 0);
    chk("hit out", h, 0);
    $display("test gateway done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Clock, watchdog well past the ~30 cycles of tests, main sequence
  initial forever #12.5 mclk = ~mclk;
  initial begin
    #50000;
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    arst_n = 1;
    t_cfg;
    t_base;
    t_gw;
    print_verdict;
  end
endmodule
`default_nettype wire
